// ### rtl/ccf_pkg.sv
// constants, opcodes and state type for the core flow and stack control
package ccf_pkg;

   // reset values
   localparam logic [15:0] PC_RESET = 16'h0000;
   // top of internal data sram, plain default for this build
   localparam logic [15:0] STK_RESET = 16'h17ff;
   // instructions during which interrupts stay blocked after a low-byte write
   localparam logic [2:0] HOLD_INSNS = 3'h4;

   // io space addresses of the core registers
   localparam logic [4:0] IO_STK_LO = 5'h1d;
   localparam logic [4:0] IO_STK_HI = 5'h1e;
   localparam logic [4:0] IO_SFLAG = 5'h1f;

   // status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_I = 7;

   // opcodes, field [15:10], jmp and call take a second word; [15:14] = 2'b11 is the immediate group
   localparam logic [5:0] OP_ADD = 6'h00;
   localparam logic [5:0] OP_ADC = 6'h01;
   localparam logic [5:0] OP_SUB = 6'h02;
   localparam logic [5:0] OP_SBC = 6'h03;
   localparam logic [5:0] OP_AND = 6'h04;
   localparam logic [5:0] OP_OR = 6'h05;
   localparam logic [5:0] OP_EOR = 6'h06;
   localparam logic [5:0] OP_MOV = 6'h07;
   localparam logic [5:0] OP_MUL = 6'h08;
   localparam logic [5:0] OP_FMULSU = 6'h0d;
   localparam logic [5:0] OP_PUSH = 6'h10;
   localparam logic [5:0] OP_POP = 6'h11;
   localparam logic [5:0] OP_IN = 6'h12;
   localparam logic [5:0] OP_OUT = 6'h13;
   localparam logic [5:0] OP_JMP = 6'h14;
   localparam logic [5:0] OP_CALL = 6'h15;
   localparam logic [5:0] OP_RELATIVE_INVOKE = 6'h16;
   localparam logic [5:0] OP_INDIRECT_INVOKE = 6'h17;
   localparam logic [5:0] OP_SUB_EXIT = 6'h18;
   localparam logic [5:0] OP_HANDLER_EXIT = 6'h19;
   // immediate group sub-ops, field [13:12]
   localparam logic [1:0] IMM_LDI = 2'h0;
   localparam logic [1:0] IMM_SUBI = 2'h1;
   localparam logic [1:0] IMM_ANDI = 2'h2;

   typedef enum logic [2:0] {
      ST_EXEC, ST_MUL2, ST_POP_LO, ST_PUSH_HI, ST_RTN_HI, ST_RTN_LO
   } ccf_state_t;

endpackage : ccf_pkg

// ### rtl/ccf_core.sv
// core fetch/execute flow, alu, multiplier and stack control
`timescale 1ns/1ps
`default_nettype none

module ccf_core
   import ccf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   output logic [15:0] pm_addr,
   input wire logic [15:0] pm_rdata,
   output logic [15:0] dm_addr,
   output logic [7:0] dm_wdata,
   output logic dm_we,
   output logic dm_re,
   input wire logic [7:0] dm_rdata,
   input wire logic irq,
   input wire logic [15:0] irq_vector,
   output logic irq_ack,
   output logic [7:0] status_flags,
   output logic [15:0] stack_pointer
);

   ////////////////////////////////////////////////////////////////////////
   // state
   ccf_state_t state_ff, nxt_state;
   logic [15:0] pc_ff, nxt_pc;
   logic [15:0] ir_ff, nxt_ir;
   logic iv_ff, nxt_iv;
   logic [15:0] stkptr_ff, nxt_stkptr;
   logic [7:0] sflag_ff, nxt_sflag;
   logic [7:0] tmp_hi_ff, rtn_hi_ff, nxt_rtn_hi;
   logic [2:0] hold_ff, nxt_hold;
   logic [7:0] mul_a_ff, mul_b_ff;
   logic [2:0] mul_mode_ff;
   logic [4:0] pop_dst_ff;
   logic [15:0] dm_addr_ff, nxt_dm_addr;
   logic [7:0] dm_wdata_ff, nxt_dm_wdata;
   logic dm_we_ff, nxt_dm_we, dm_re_ff, nxt_dm_re;
   logic [7:0] rf_ff [32];

   ////////////////////////////////////////////////////////////////////////
   // decode of the executing word
   wire [5:0] op6 = ir_ff[15:10];
   wire [4:0] rr = ir_ff[4:0];
   wire is_imm = (ir_ff[15:14] == 2'b11);
   wire [1:0] imm_op = ir_ff[13:12];
   wire [4:0] d_idx = is_imm ? {1'b1, ir_ff[11:8]} : ir_ff[9:5];
   wire is_alu = !is_imm && (op6 <= OP_MOV);
   wire is_mul = !is_imm && (op6 >= OP_MUL) && (op6 <= OP_FMULSU);
   wire is_push = (op6 == OP_PUSH);
   wire is_pop = (op6 == OP_POP);
   wire is_in = (op6 == OP_IN);
   wire is_out = (op6 == OP_OUT);
   wire is_jmp = (op6 == OP_JMP);
   wire is_call = (op6 == OP_CALL);
   wire is_rel = (op6 == OP_RELATIVE_INVOKE);
   wire is_ind = (op6 == OP_INDIRECT_INVOKE);
   wire is_exit = (op6 == OP_SUB_EXIT) || (op6 == OP_HANDLER_EXIT);
   wire is_invoke = is_call || is_rel || is_ind;

   // irq is taken in place of the waiting word, only when not held off
   wire ex = (state_ff == ST_EXEC) && iv_ff;
   wire take_irq = ex && irq && sflag_ff[FLAG_I] && (hold_ff == 3'h0);
   wire run = ex && !take_irq;
   wire out_stk_lo = run && is_out && (rr == IO_STK_LO);
   wire out_sflag = run && is_out && (rr == IO_SFLAG);

   ////////////////////////////////////////////////////////////////////////
   // alu, operands straight from the register array
   wire [7:0] op_a = rf_ff[d_idx];
   wire [7:0] op_b = is_imm ? ir_ff[7:0] : rf_ff[rr];
   wire use_c = !is_imm && ((op6 == OP_ADC) || (op6 == OP_SBC));
   wire [7:0] cin = {7'h00, use_c & sflag_ff[FLAG_C]};
   wire [8:0] sum9 = {1'b0, op_a} + {1'b0, op_b} + {1'b0, cin};
   wire [8:0] dif9 = {1'b0, op_a} - {1'b0, op_b} - {1'b0, cin};
   wire k_add = is_alu && (op6 <= OP_ADC);
   wire k_sub = (is_alu && (op6 == OP_SUB || op6 == OP_SBC))
      || (is_imm && imm_op == IMM_SUBI);
   wire k_and = (is_alu && op6 == OP_AND) || (is_imm && imm_op == IMM_ANDI);
   wire k_or = (is_alu && op6 == OP_OR) || (is_imm && imm_op == 2'h3);
   wire k_eor = is_alu && op6 == OP_EOR;
   wire k_mov = (is_alu && op6 == OP_MOV) || (is_imm && imm_op == IMM_LDI);
   wire [7:0] alu_res = k_add ? sum9[7:0] : k_sub ? dif9[7:0] :
      k_and ? (op_a & op_b) : k_or ? (op_a | op_b) :
      k_eor ? (op_a ^ op_b) : op_b;
   // half carry and overflow per add or subtract form
   wire h_add = (op_a[3] & op_b[3]) | (op_b[3] & ~alu_res[3])
      | (~alu_res[3] & op_a[3]);
   wire h_sub = (~op_a[3] & op_b[3]) | (op_b[3] & alu_res[3])
      | (alu_res[3] & ~op_a[3]);
   wire v_add = (op_a[7] & op_b[7] & ~alu_res[7])
      | (~op_a[7] & ~op_b[7] & alu_res[7]);
   wire v_sub = (op_a[7] & ~op_b[7] & ~alu_res[7])
      | (~op_a[7] & op_b[7] & alu_res[7]);
   wire f_c = k_add ? sum9[8] : k_sub ? dif9[8] : sflag_ff[FLAG_C];
   wire f_h = k_add ? h_add : k_sub ? h_sub : sflag_ff[FLAG_H];
   wire f_v = k_add ? v_add : k_sub ? v_sub : 1'b0;
   wire f_n = alu_res[7];
   wire [7:0] alu_flags = {sflag_ff[7:6], f_h, f_n ^ f_v, f_v, f_n,
      (alu_res == 8'h00), f_c};
   wire flag_op = run && (is_alu || is_imm) && !k_mov;

   ////////////////////////////////////////////////////////////////////////
   // multiplier second stage; mode is {sign a, sign b, fraction}
   wire signed [17:0] mprod = $signed({mul_mode_ff[2] & mul_a_ff[7], mul_a_ff})
      * $signed({mul_mode_ff[1] & mul_b_ff[7], mul_b_ff});
   wire [15:0] prod = mul_mode_ff[0] ? {mprod[14:0], 1'b0} : mprod[15:0];
   wire mul_we = (state_ff == ST_MUL2);
   // operand modes per opcode, mul..fmulsu in order
   wire [2:0] mode_sel = (op6 == 6'h09) ? 3'b110 : (op6 == 6'h0a) ? 3'b100 :
      (op6 == 6'h0b) ? 3'b001 : (op6 == 6'h0c) ? 3'b111 :
      (op6 == OP_FMULSU) ? 3'b101 : 3'b000;

   ////////////////////////////////////////////////////////////////////////
   // io reads of the core registers
   wire [7:0] io_rd = (rr == IO_STK_LO) ? stkptr_ff[7:0] :
      (rr == IO_STK_HI) ? tmp_hi_ff :
      (rr == IO_SFLAG) ? sflag_ff : 8'h00;

   // single byte write port into the register file
   wire rf_we = (run && (is_alu || is_imm || is_in)) || (state_ff == ST_POP_LO);
   wire [4:0] rf_wa = (state_ff == ST_POP_LO) ? pop_dst_ff : d_idx;
   wire [7:0] rf_wd = (state_ff == ST_POP_LO) ? dm_rdata :
      is_in ? io_rd : alu_res;

   // invoke targets and return word pointers; pc counts words, so pc is
   // already the byte address shifted right
   wire [15:0] rel_off = {{6{ir_ff[9]}}, ir_ff[9:0]};
   wire [15:0] z_ptr = {rf_ff[31], rf_ff[30]};
   wire [15:0] call_tgt = is_call ? pm_rdata : is_rel ? pc_ff + rel_off : z_ptr;
   wire [15:0] call_rtn = is_call ? pc_ff + 16'h0001 : pc_ff;
   wire [15:0] irq_rtn = pc_ff - 16'h0001;
   wire [15:0] stk_up = stkptr_ff + 16'h0001;
   wire [15:0] stk_dn = stkptr_ff - 16'h0001;

   ////////////////////////////////////////////////////////////////////////
   // flow, stack and data port sequencing
   always_comb
   begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_ir = ir_ff;
      nxt_iv = iv_ff;
      nxt_stkptr = stkptr_ff;
      nxt_rtn_hi = rtn_hi_ff;
      nxt_dm_addr = stkptr_ff;
      nxt_dm_wdata = 8'h00;
      nxt_dm_we = 1'b0;
      nxt_dm_re = 1'b0;
      case (state_ff)
         ST_EXEC:
         begin
            if (take_irq)
            begin
               // entry: low byte first at the current top
               nxt_dm_we = 1'b1;
               nxt_dm_wdata = irq_rtn[7:0];
               nxt_stkptr = stk_dn;
               nxt_rtn_hi = irq_rtn[15:8];
               nxt_pc = irq_vector;
               nxt_iv = 1'b0;
               nxt_state = ST_PUSH_HI;
            end
            else
            begin
               // prefetch the word at pc while ir executes
               nxt_ir = pm_rdata;
               nxt_pc = pc_ff + 16'h0001;
               nxt_iv = 1'b1;
               if (iv_ff)
               begin
                  if (is_mul)
                     nxt_state = ST_MUL2;
                  if (is_push)
                  begin
                     nxt_dm_we = 1'b1;
                     nxt_dm_wdata = op_a;
                     nxt_stkptr = stk_dn;
                  end
                  if (is_pop)
                  begin
                     nxt_dm_re = 1'b1;
                     nxt_dm_addr = stk_up;
                     nxt_stkptr = stk_up;
                     nxt_state = ST_POP_LO;
                  end
                  if (is_jmp)
                  begin
                     // second word is the word now on the fetch bus
                     nxt_pc = pm_rdata;
                     nxt_iv = 1'b0;
                  end
                  if (is_invoke)
                  begin
                     nxt_dm_we = 1'b1;
                     nxt_dm_wdata = call_rtn[7:0];
                     nxt_stkptr = stk_dn;
                     nxt_rtn_hi = call_rtn[15:8];
                     nxt_pc = call_tgt;
                     nxt_iv = 1'b0;
                     nxt_state = ST_PUSH_HI;
                  end
                  if (is_exit)
                  begin
                     // flags are left alone on either exit
                     nxt_dm_re = 1'b1;
                     nxt_dm_addr = stk_up;
                     nxt_stkptr = stk_up;
                     nxt_iv = 1'b0;
                     nxt_state = ST_RTN_HI;
                  end
                  if (is_out && rr == IO_STK_LO)
                     nxt_stkptr = {stkptr_ff[15:8], op_a};
                  if (is_out && rr == IO_STK_HI)
                     nxt_stkptr = {op_a, stkptr_ff[7:0]};
               end
            end
         end
         ST_PUSH_HI:
         begin
            nxt_dm_we = 1'b1;
            nxt_dm_wdata = rtn_hi_ff;
            nxt_stkptr = stk_dn;
            nxt_state = ST_EXEC;
         end
         ST_RTN_HI:
         begin
            nxt_rtn_hi = dm_rdata;
            nxt_dm_re = 1'b1;
            nxt_dm_addr = stk_up;
            nxt_stkptr = stk_up;
            nxt_state = ST_RTN_LO;
         end
         ST_RTN_LO:
         begin
            nxt_pc = {rtn_hi_ff, dm_rdata};
            nxt_state = ST_EXEC;
         end
         ST_MUL2, ST_POP_LO:
            nxt_state = ST_EXEC;
         default:
            nxt_state = ST_EXEC;
      endcase
   end

   // flag register: io write beats an alu update in the same instruction
   always_comb
   begin
      nxt_sflag = sflag_ff;
      if (out_sflag)
         nxt_sflag = op_a;
      else if (flag_op)
         nxt_sflag = alu_flags;
      else if (mul_we)
      begin
         nxt_sflag[FLAG_C] = mprod[15];
         nxt_sflag[FLAG_Z] = (prod == 16'h0000);
      end
   end

   // hold-off counts executed instructions; any other io write ends it
   always_comb
   begin
      nxt_hold = hold_ff;
      if (out_stk_lo)
         nxt_hold = HOLD_INSNS;
      else if (run && is_out)
         nxt_hold = 3'h0;
      else if (run && hold_ff != 3'h0)
         nxt_hold = hold_ff - 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // control flops, one step per clk edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= ST_EXEC;
         pc_ff <= PC_RESET;
         iv_ff <= 1'b0;
         stkptr_ff <= STK_RESET;
         sflag_ff <= 8'h00;
         hold_ff <= 3'h0;
         dm_we_ff <= 1'b0;
         dm_re_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         iv_ff <= nxt_iv;
         stkptr_ff <= nxt_stkptr;
         sflag_ff <= nxt_sflag;
         hold_ff <= nxt_hold;
         dm_we_ff <= nxt_dm_we;
         dm_re_ff <= nxt_dm_re;
      end
   end

   // data path flops, no reset needed beyond a defined start
   always_ff @(posedge clk)
   begin
      ir_ff <= rst ? 16'h0000 : nxt_ir;
      rtn_hi_ff <= rst ? 8'h00 : nxt_rtn_hi;
      dm_addr_ff <= rst ? 16'h0000 : nxt_dm_addr;
      dm_wdata_ff <= rst ? 8'h00 : nxt_dm_wdata;
      tmp_hi_ff <= (rst) ? 8'h00 :
         (run && is_in && rr == IO_STK_LO) ? stkptr_ff[15:8] : tmp_hi_ff;
      mul_a_ff <= (state_ff == ST_EXEC) ? op_a : mul_a_ff;
      mul_b_ff <= (state_ff == ST_EXEC) ? op_b : mul_b_ff;
      mul_mode_ff <= (state_ff == ST_EXEC) ? mode_sel : mul_mode_ff;
      pop_dst_ff <= (state_ff == ST_EXEC) ? d_idx : pop_dst_ff;
   end

   // register file; product lands in r1:r0 in the second multiply cycle
   for (genvar gi = 0; gi < 32; gi++)
   begin : g_rf
      wire hit = rf_we && (rf_wa == 5'(gi));
      always_ff @(posedge clk)
      begin
         if (rst)
            rf_ff[gi] <= 8'h00;
         else if (mul_we && gi == 0)
            rf_ff[gi] <= prod[7:0];
         else if (mul_we && gi == 1)
            rf_ff[gi] <= prod[15:8];
         else if (hit)
            rf_ff[gi] <= rf_wd;
      end
   end

   assign pm_addr = pc_ff;
   assign dm_addr = dm_addr_ff;
   assign dm_wdata = dm_wdata_ff;
   assign dm_we = dm_we_ff;
   assign dm_re = dm_re_ff;
   assign irq_ack = take_irq;
   assign status_flags = sflag_ff;
   assign stack_pointer = stkptr_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_lo_push;
      dm_we && dm_addr == $past(stkptr_ff, 1);
   endsequence
   sequence s_hi_push;
      dm_we && dm_addr == $past(dm_addr) - 16'h0001;
   endsequence

   reset_start_a: assert property ($fell(rst) |-> pc_ff == PC_RESET
      && stkptr_ff == STK_RESET && iv_ff == 1'b0)
      else $error("reset did not start at address zero");
   fetch_step_a: assert property (run && is_alu |=>
      pc_ff == $past(pc_ff) + 16'h0001 && iv_ff)
      else $error("fetch did not advance with execution");
   mul_two_a: assert property (run && is_mul |=> mul_we ##1
      state_ff == ST_EXEC && rf_ff[0] == $past(prod[7:0]))
      else $error("multiply did not finish in two cycles");
   alu_flags_a: assert property (run && k_add && !out_sflag |=>
      sflag_ff[FLAG_Z] == (rf_ff[$past(d_idx)] == 8'h00))
      else $error("zero flag does not match result");
   push_byte_a: assert property (run && is_push |=>
      stkptr_ff == $past(stkptr_ff) - 16'h0001 && dm_we
      && dm_addr == $past(stkptr_ff))
      else $error("push did not step pointer down by one");
   invoke_order_a: assert property (run && is_invoke |=>
      s_lo_push ##1 s_hi_push)
      else $error("return address bytes pushed out of order");
   invoke_two_a: assert property (run && is_invoke |=> ##1
      stkptr_ff == $past(stkptr_ff, 2) - 16'h0002)
      else $error("invoke did not lower pointer by two");
   exit_pop_a: assert property (run && is_exit |=> ##2
      stkptr_ff == $past(stkptr_ff, 3) + 16'h0002
      && sflag_ff == $past(sflag_ff, 3))
      else $error("exit did not raise pointer by two");
   irq_flags_a: assert property (irq_ack |=>
      sflag_ff == $past(sflag_ff) [*2])
      else $error("status flags changed on interrupt entry");
   hold_block_a: assert property (out_stk_lo |=>
      hold_ff == HOLD_INSNS && !irq_ack)
      else $error("interrupt taken inside hold-off");
   temp_read_a: assert property (run && is_in && rr == IO_STK_LO |=>
      tmp_hi_ff == $past(stkptr_ff[15:8]))
      else $error("high byte not copied on low read");

endmodule : ccf_core

`default_nettype wire

// ### verif/ccf_mem.sv
// program rom and data sram model facing the core
`timescale 1ns/1ps
`default_nettype none

module ccf_mem
(
   input wire logic clk,
   input wire logic [15:0] pm_addr,
   output logic [15:0] pm_rdata,
   input wire logic [15:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_we,
   input wire logic dm_re,
   output logic [7:0] dm_rdata
);
   logic [15:0] rom [0:255];
   logic [7:0] ram [0:65535];
   logic [7:0] last_ff = 8'h5a;

   ////////////////////////////////////////////////////////////////////////
   // async rom; only 256 words decoded, enough for the bench programs
   assign pm_rdata = rom[pm_addr[7:0]];
   // unselected bus shows the inverse of the last byte, never a stale match
   assign dm_rdata = dm_re ? ram[dm_addr] : ~last_ff;

   // write at the strobed edge, remember the last byte read
   always @(posedge clk)
   begin
      if (dm_we)
         ram[dm_addr] <= dm_wdata;
      if (dm_re)
         last_ff <= ram[dm_addr];
   end

endmodule : ccf_mem
`default_nettype wire

// ### verif/cpu_core_flow_and_stack_tb.sv
// self-checking bench for the core flow and stack control
`timescale 1ns/1ps
`default_nettype none

module cpu_core_flow_and_stack_tb import ccf_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic irq = 1'b0;
   logic [15:0] irq_vector = 16'h0050;
   logic [15:0] pm_addr, pm_rdata, dm_addr, stack_pointer;
   logic [7:0] dm_wdata, dm_rdata, status_flags, k1, k2, sum;
   logic [15:0] prod, s1, stk;
   logic dm_we, dm_re, irq_ack, spl_seen, ack_seen;
   logic [1:0] fl_add, fl_mul;
   int n_errors = 0;
   int n_checks = 0;
   int seed = 69;
   int cyc, t_spl, n_ack, nw, w;
   int qa[$], qd[$], ra[$];

   ccf_core ccf_core_i (.clk(clk), .rst(rst), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
      .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata), .irq(irq),
      .irq_vector(irq_vector), .irq_ack(irq_ack),
      .status_flags(status_flags), .stack_pointer(stack_pointer));
   ccf_mem ccf_mem_i (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
      .dm_re(dm_re), .dm_rdata(dm_rdata));

   ////////////////////////////////////////////////////////////////////////
   // 250 mhz core clock
   always #2 clk = ~clk;

   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////
   // monitor: every memory strobe is matched against the model queues
   always @(posedge clk)
   begin
      if (rst)
      begin
         spl_seen = 1'b0;
         ack_seen = 1'b0;
         n_ack = 0;
         nw = 0;
         cyc = 0;
      end
      else
      begin
         cyc++;
         if (!spl_seen && stack_pointer === s1)
         begin
            spl_seen = 1'b1;
            t_spl = cyc;
         end
         if (dm_we)
         begin
            if (nw == 0)
               check("add flags", {status_flags[FLAG_Z], status_flags[FLAG_C]}, fl_add);
            if (nw == 1)
               check("mul flags", {status_flags[FLAG_Z], status_flags[FLAG_C]}, fl_mul);
            nw++;
            if (qa.size() == 0)
               check("write count", 16'h0001, 16'h0000);
            else
            begin
               check("write addr", dm_addr, 16'(qa.pop_front()));
               w = qd.pop_front();
               if (w >= 0)
                  check("write data", {8'h00, dm_wdata}, 16'(w));
            end
         end
         if (dm_re)
         begin
            if (ra.size() == 0)
               check("read count", 16'h0001, 16'h0000);
            else
               check("read addr", dm_addr, 16'(ra.pop_front()));
         end
         if (irq_ack)
         begin
            ack_seen = 1'b1;
            n_ack++;
            check("hold-off gap", 16'(cyc - t_spl inside {[4:5]}), 16'h0001);
         end
      end
   end

   // interrupt source: raised once the pointer reaches s1, dropped after ack
   always @(negedge clk)
      irq <= spl_seen && !ack_seen && !rst;

   ////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond three program runs
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      summarize();
   end

   // main sequence: the same program three times with fresh operands
   initial
   begin
      stk = STK_RESET;
      s1 = {STK_RESET[15:8], 8'h10};
      for (int i = 0; i < 256; i++)
         ccf_mem_i.rom[i] = {OP_MOV, 5'h14, 5'h14};
      for (int run = 0; run < 3; run++)
      begin
         rst = 1'b1;
         k1 = 8'($random(seed));
         k2 = 8'($random(seed));
         sum = k1 + k2;
         prod = sum * k2;
         fl_add = {sum == 8'h00, 9'({1'b0, k1} + k2) >> 8 == 9'h001};
         fl_mul = {prod == 16'h0000, prod[15]};
         ccf_mem_i.rom[0] = {2'h3, IMM_LDI, 4'h0, k1};
         ccf_mem_i.rom[1] = {2'h3, IMM_LDI, 4'h1, k2};
         ccf_mem_i.rom[2] = {OP_ADD, 5'h10, 5'h11};
         ccf_mem_i.rom[3] = {OP_PUSH, 5'h10, 5'h10};
         ccf_mem_i.rom[4] = {OP_MUL, 5'h10, 5'h11};
         ccf_mem_i.rom[5] = {OP_PUSH, 5'h00, 5'h00};
         ccf_mem_i.rom[6] = {OP_PUSH, 5'h01, 5'h01};
         ccf_mem_i.rom[7] = {OP_CALL, 10'h000};
         ccf_mem_i.rom[8] = 16'h0040;
         ccf_mem_i.rom[9] = {OP_POP, 5'h02, 5'h02};
         ccf_mem_i.rom[10] = {OP_PUSH, 5'h02, 5'h02};
         ccf_mem_i.rom[11] = {2'h3, IMM_LDI, 4'h2, 8'h80};
         ccf_mem_i.rom[12] = {OP_OUT, 5'h12, IO_SFLAG};
         ccf_mem_i.rom[13] = {2'h3, IMM_LDI, 4'h3, 8'h10};
         // relocated stack stays well above sram start
         ccf_mem_i.rom[14] = {OP_OUT, 5'h13, IO_STK_LO};
         // read the pointer back, low byte first so the high copy is taken
         ccf_mem_i.rom[15] = {OP_IN, 5'h14, IO_STK_LO};
         ccf_mem_i.rom[16] = {OP_IN, 5'h15, IO_STK_HI};
         ccf_mem_i.rom[21] = {OP_PUSH, 5'h10, 5'h10};
         ccf_mem_i.rom[22] = {OP_JMP, 10'h000};
         ccf_mem_i.rom[23] = 16'h0016;
         ccf_mem_i.rom[8'h40] = {OP_SUB_EXIT, 10'h000};
         ccf_mem_i.rom[8'h50] = {OP_HANDLER_EXIT, 10'h000};
         // expected traffic; -1 marks an interrupt return byte
         qa = '{stk, stk - 1, stk - 2, stk - 3, stk - 4, stk - 2, s1, s1 - 1, s1};
         qd = '{sum, prod[7:0], prod[15:8], 8'h09, 8'h00, prod[15:8], -1, -1, sum};
         ra = '{stk - 4, stk - 3, stk - 2, s1 - 1, s1};
         repeat (16) @(negedge clk);
         check("stack reset", stack_pointer, STK_RESET);
         check("fetch start", pm_addr, PC_RESET);
         rst = 1'b0;
         for (int i = 0; i < 300 && qa.size() + ra.size() > 0; i++)
            @(negedge clk);
         check("pending", 16'(qa.size() + ra.size()), 16'h0000);
         check("final flags", {8'h00, status_flags}, 16'h0080);
         check("final stack", stack_pointer, s1 - 1);
         check("sp low read", {8'h00, ccf_core_i.rf_ff[20]}, 16'h0010);
         check("sp high read", {8'h00, ccf_core_i.rf_ff[21]}, {8'h00, STK_RESET[15:8]});
         check("acks", 16'(n_ack), 16'h0001);
      end
      summarize();
   end

endmodule : cpu_core_flow_and_stack_tb
`default_nettype wire
